// ==== logic/spimsd_top.sv ====
// serial master: apb registers, status flags, receive buffer, rate divider
//
// What this block does
// - set transfer done flag, status bit 7, when a byte exchange ends.
// - clear transfer done when an exchange starts or the clear sequence ends.
// - set write collision flag, status bit 6, on a colliding data write.
// - write collision stays low without a collision; clear sequence clears it.
// - set mode fault flag, status bit 4, on select level wrong for mode.
// - mode fault stays clear with proper select level or after clear sequence.
// - status bits 5 and 3..0 reserved; software writes no ones there.
// - after reset status bits 7, 6 and 4 read zero.
// - a data write loads the shift register directly, no transmit buffer.
// - a data read returns the receive buffer, never the live shift register.
// - data register holds eight received bits; reads zero after reset.
// - all registers may be read and written whenever no exchange runs.
// - clearing enable during an exchange stops the peripheral at once.
// - a data write during an exchange is a write collision condition.
// - transmit interrupt request follows the transfer done flag.
// - receive error request follows mode fault unless select check disabled.
// - rate codes 0..6 divide by 2 to 128; code 7 uses baud ticks.
// - polarity sets idle clock level; phase picks leading or trailing sampling.
`timescale 1ns/1ps
module spimsd_top
  import spimsd_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // serial link
  output logic o_sck,
  output logic o_mosi,
  input wire logic i_miso,
  input wire logic i_ss_n,
  // external baud generator, one pulse per half clock period
  input wire logic i_brg_tick,
  // interrupt requests
  output logic o_irq_tx,
  output logic o_irq_rx
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic done_f;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic armed;
    logic [7:0] rxbuf;
    logic [SPIMSD_DIV_W-1:0] div;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq_tx;
    logic irq_rx;
    logic ss_m;
    logic ss_s;
    logic miso_m;
    logic miso_s;
    logic start;
    logic [7:0] txb;
  } spimsd_regs_t;

  localparam spimsd_regs_t SPIMSD_REGS_RST = '{
    ctrl: SPIMSD_CTRL_RESET,
    ss_m: 1'b1,
    ss_s: 1'b1,
    default: '0
  };

  // half period of the serial clock in system clocks
  function automatic logic [SPIMSD_DIV_W-1:0] spimsd_half(input logic [2:0] code);
    spimsd_half = SPIMSD_DIV_W'(1) << code;
  endfunction

  function automatic logic spimsd_hit(input logic [7:0] a, input logic [7:0] off);
    spimsd_hit = (a == off);
  endfunction

  spimsd_regs_t r;
  spimsd_regs_t next_r;
  spimsd_if sbus ();

  logic setup;
  logic acc;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_data;
  logic wr_data;
  logic busy;
  logic fault;
  logic tick;
  logic [2:0] rate;
  logic [7:0] stat_word;

  always_comb
  begin
    setup = i_psel && !i_penable;
    acc = i_psel && i_penable && r.pready;
    hit_ctrl = spimsd_hit(i_paddr, SPIMSD_OFF_CTRL);
    hit_stat = spimsd_hit(i_paddr, SPIMSD_OFF_STAT);
    hit_data = spimsd_hit(i_paddr, SPIMSD_OFF_DATA);
    wr_data = acc && i_pwrite && hit_data;
    // a start pulse not yet seen by the shifter counts as running
    busy = sbus.busy || r.start;
    // a master sees a low select as another master driving the bus
    fault = r.ctrl[SPIMSD_CTRL_EN] && r.ctrl[SPIMSD_CTRL_MASTER] && !r.ss_s;
    rate = {r.ctrl[SPIMSD_CTRL_RATE_HI], r.ctrl[SPIMSD_CTRL_RATE_MID],
      r.ctrl[SPIMSD_CTRL_RATE_LO]};
    if (rate == SPIMSD_RATE_EXT)
      tick = i_brg_tick;
    else
      tick = (r.div == spimsd_half(rate) - SPIMSD_DIV_W'(1));
    // reserved bits read as zero
    stat_word = '0;
    stat_word[SPIMSD_STAT_DONE] = r.done_f;
    stat_word[SPIMSD_STAT_COLLIDE] = r.write_collision_flag;
    stat_word[SPIMSD_STAT_FAULT] = r.mode_fault_flag;
  end

  always_comb
  begin
    next_r = r;
    next_r.start = 1'b0;
    // pin synchronisers
    next_r.ss_m = i_ss_n;
    next_r.ss_s = r.ss_m;
    next_r.miso_m = i_miso;
    next_r.miso_s = r.miso_m;

    // apb answer one cycle after setup, so every access has one wait-free access phase
    next_r.pready = setup;
    next_r.pslverr = setup && !(hit_ctrl || hit_stat || hit_data);
    next_r.prdata = '0;
    if (setup && !i_pwrite)
    begin
      if (hit_ctrl)
        next_r.prdata[7:0] = r.ctrl;
      else if (hit_stat)
        next_r.prdata[7:0] = stat_word;
      else if (hit_data)
        next_r.prdata[7:0] = r.rxbuf;
    end

    // control writes take effect at any time; software keeps them steady mid-byte
    if (acc && i_pwrite && hit_ctrl)
      next_r.ctrl = i_pwdata[7:0];

    // first half of the clear sequence
    if (acc && !i_pwrite && hit_stat)
      next_r.armed = 1'b1;
    // second half: any data access after the status read
    if (acc && hit_data && r.armed)
    begin
      next_r.armed = 1'b0;
      next_r.done_f = 1'b0;
      next_r.write_collision_flag = 1'b0;
      next_r.mode_fault_flag = 1'b0;
    end

    if (wr_data)
    begin
      if (busy)
        next_r.write_collision_flag = 1'b1;
      else if (r.ctrl[SPIMSD_CTRL_EN] && r.ctrl[SPIMSD_CTRL_MASTER])
      begin
        next_r.start = 1'b1;
        next_r.txb = i_pwdata[7:0];
        next_r.done_f = 1'b0;
      end
    end

    // hardware sets come last so they win over a clear in the same cycle
    if (sbus.done)
    begin
      next_r.done_f = 1'b1;
      next_r.rxbuf = sbus.rx;
    end
    if (fault)
      next_r.mode_fault_flag = 1'b1;

    // rate divider runs only during an exchange
    if (!sbus.busy || tick)
      next_r.div = '0;
    else
      next_r.div = r.div + SPIMSD_DIV_W'(1);

    next_r.irq_tx = next_r.done_f;
    next_r.irq_rx = next_r.mode_fault_flag && !next_r.ctrl[SPIMSD_CTRL_SEL_CHK_DIS];
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      r <= SPIMSD_REGS_RST;
    else
      r <= next_r;
  end

  // shifter control
  assign sbus.start = r.start;
  assign sbus.tx = r.txb;
  assign sbus.abort = !r.ctrl[SPIMSD_CTRL_EN] || !r.ctrl[SPIMSD_CTRL_MASTER];
  assign sbus.tick = tick;
  assign sbus.clock_polarity = r.ctrl[SPIMSD_CTRL_CLOCK_POLARITY];
  assign sbus.clock_phase = r.ctrl[SPIMSD_CTRL_CLOCK_PHASE];
  assign sbus.miso = r.miso_s;

  spimsd_shifter u_shifter (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .bus(sbus.shift)
  );

  assign o_pready = r.pready;
  assign o_prdata = r.prdata;
  assign o_pslverr = r.pslverr;
  assign o_sck = sbus.sck;
  assign o_mosi = sbus.mosi;
  assign o_irq_tx = r.irq_tx;
  assign o_irq_rx = r.irq_rx;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  a_done_sets_flag: assert property (
    sbus.done |=> r.done_f && r.irq_tx)
    else $error("transfer done flag not set after exchange");

  a_start_clears_done: assert property (
    r.start |-> !r.done_f ##1 sbus.busy)
    else $error("exchange started with done flag still set");

  a_busy_write_collides: assert property (
    wr_data && busy |=> r.write_collision_flag && $stable(r.txb) && !r.start)
    else $error("collision not flagged or byte disturbed");

  a_collision_cause: assert property (
    $rose(r.write_collision_flag) |-> $past(wr_data && busy))
    else $error("collision flag set without a collision");

  a_fault_sets_flag: assert property (
    fault |=> r.mode_fault_flag)
    else $error("mode fault not flagged");

  a_fault_needs_cause: assert property (
    $rose(r.mode_fault_flag) |-> $past(fault))
    else $error("mode fault flag set without a fault");

  a_stat_reserved: assert property (
    setup && !i_pwrite && hit_stat |=> (r.prdata[5] == 1'b0) && (r.prdata[3:0] == 4'h0))
    else $error("reserved status bits not zero");

  a_reset_flags: assert property (
    $past(i_srst) |-> !r.done_f && !r.write_collision_flag && !r.mode_fault_flag)
    else $error("status flags not zero after reset");

  a_write_loads_tx: assert property (
    wr_data && !busy && !sbus.abort |=> r.start && (r.txb == $past(i_pwdata[7:0])))
    else $error("data write did not load the shifter");

  a_read_rxbuf: assert property (
    setup && !i_pwrite && hit_data |=> r.prdata[7:0] == $past(r.rxbuf))
    else $error("data read not from receive buffer");

  a_clear_sequence: assert property (
    acc && hit_data && r.armed && !sbus.done && !fault && !(wr_data && busy)
    |=> !r.done_f && !r.write_collision_flag && !r.mode_fault_flag)
    else $error("clear sequence left a flag set");

  a_irq_rx_gate: assert property (
    r.mode_fault_flag && !r.ctrl[SPIMSD_CTRL_SEL_CHK_DIS] && $stable(r.ctrl) |-> r.irq_rx)
    else $error("receive error request missing");

  a_rate_period: assert property (
    sbus.busy && !sbus.abort |=> (sbus.sck != $past(sbus.sck)) == $past(tick))
    else $error("serial clock moved off the divider tick");

  c_exchange_done: cover property (r.start ##[1:300] sbus.done);
  c_collision: cover property (wr_data && busy);
  c_mode_fault: cover property ($rose(r.mode_fault_flag));
  c_clear_seq: cover property (r.armed && acc && hit_data && r.done_f);

endmodule // spimsd_top

// ==== include/spimsd_pkg.sv ====
// constants and types shared by the serial master status and data block
package spimsd_pkg;
  // register byte addresses on the apb bus
  localparam logic [7:0] SPIMSD_OFF_CTRL = 8'h00;
  localparam logic [7:0] SPIMSD_OFF_STAT = 8'h04;
  localparam logic [7:0] SPIMSD_OFF_DATA = 8'h08;
  // control register fields
  localparam int SPIMSD_CTRL_RATE_HI = 7;
  localparam int SPIMSD_CTRL_EN = 6;
  localparam int SPIMSD_CTRL_SEL_CHK_DIS = 5;
  localparam int SPIMSD_CTRL_MASTER = 4;
  localparam int SPIMSD_CTRL_CLOCK_POLARITY = 3;
  localparam int SPIMSD_CTRL_CLOCK_PHASE = 2;
  localparam int SPIMSD_CTRL_RATE_MID = 1;
  localparam int SPIMSD_CTRL_RATE_LO = 0;
  localparam logic [7:0] SPIMSD_CTRL_RESET = 8'h14;
  // status register fields
  localparam int SPIMSD_STAT_DONE = 7;
  localparam int SPIMSD_STAT_COLLIDE = 6;
  localparam int SPIMSD_STAT_FAULT = 4;
  // rate code that hands the clock to the external baud generator
  localparam logic [2:0] SPIMSD_RATE_EXT = 3'h7;
  // clock edges in one byte exchange, counted from zero
  localparam logic [4:0] SPIMSD_LAST_EDGE = 5'h0F;
  localparam int SPIMSD_DIV_W = 7;

  typedef enum logic {SPIMSD_IDLE, SPIMSD_RUN} spimsd_state_t;
endpackage

// ==== include/spimsd_if.sv ====
// link between the register side and the byte shifter
`timescale 1ns/1ps
interface spimsd_if;
  logic start;
  logic abort;
  logic tick;
  logic clock_polarity;
  logic clock_phase;
  logic miso;
  logic [7:0] tx;
  logic busy;
  logic done;
  logic sck;
  logic mosi;
  logic [7:0] rx;

  modport ctrl (
    output start, abort, tick, clock_polarity, clock_phase, miso, tx,
    input busy, done, sck, mosi, rx
  );
  modport shift (
    input start, abort, tick, clock_polarity, clock_phase, miso, tx,
    output busy, done, sck, mosi, rx
  );
endinterface

// ==== logic/spimsd_shifter.sv ====
// byte shifter that drives the serial clock and data lines
`timescale 1ns/1ps
module spimsd_shifter
  import spimsd_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // register side
  spimsd_if.shift bus
);

  typedef struct packed {
    spimsd_state_t state;
    logic [4:0] edges;
    logic [7:0] sh;
    logic [7:0] rx;
    logic sck;
    logic mosi;
    logic done;
  } spimsd_shreg_t;

  spimsd_shreg_t r;
  spimsd_shreg_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    unique case (r.state)
      SPIMSD_IDLE:
      begin
        next_r.sck = bus.clock_polarity;
        if (bus.start && !bus.abort)
        begin
          next_r.state = SPIMSD_RUN;
          next_r.edges = '0;
          // phase 0 puts the first bit out before the first edge
          next_r.sh = bus.clock_phase ? bus.tx : {bus.tx[6:0], 1'b0};
          next_r.mosi = bus.clock_phase ? r.mosi : bus.tx[7];
        end
      end
      SPIMSD_RUN:
      begin
        if (bus.abort)
        begin
          next_r.state = SPIMSD_IDLE;
          next_r.sck = bus.clock_polarity;
        end
        else if (bus.tick)
        begin
          next_r.sck = ~r.sck;
          // even edges leave idle, odd edges return to it
          if (r.edges[0] == bus.clock_phase)
            next_r.rx = {r.rx[6:0], bus.miso};
          else
          begin
            next_r.mosi = r.sh[7];
            next_r.sh = {r.sh[6:0], 1'b0};
          end
          if (r.edges == SPIMSD_LAST_EDGE)
          begin
            next_r.state = SPIMSD_IDLE;
            next_r.done = 1'b1;
          end
          else
            next_r.edges = r.edges + 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      r <= '0;
    else
      r <= next_r;
  end

  assign bus.busy = (r.state == SPIMSD_RUN);
  assign bus.done = r.done;
  assign bus.sck = r.sck;
  assign bus.mosi = r.mosi;
  assign bus.rx = r.rx;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  a_idle_polarity: assert property (
    (r.state == SPIMSD_IDLE) && $past(r.state == SPIMSD_IDLE) && $stable(bus.clock_polarity)
    |-> (r.sck == bus.clock_polarity))
    else $error("serial clock not at idle level");
  a_abort_stops: assert property (
    bus.busy && bus.abort |=> !bus.busy && !bus.done)
    else $error("abort did not stop the exchange");

endmodule // spimsd_shifter

// ==== tb/spimsd_slave.sv ====
// behavioural serial slave answering in clock mode 0
`timescale 1ns/1ps
module spimsd_slave
  import spimsd_pkg::*;
(
  // serial link
  input wire logic i_sck,
  input wire logic i_mosi,
  output logic o_miso,
  // bench side
  input wire logic [7:0] i_tx,
  input wire logic i_rst,
  output logic [7:0] o_rx
);
  logic [2:0] idx = 3'h0;
  initial o_rx = 8'h00;
  // capture on the leading edge, move to the next bit on the trailing edge
  always @(posedge i_sck) o_rx <= {o_rx[6:0], i_mosi};
  // reset swallows the unknown-to-low step of the clock at power-up
  always @(negedge i_sck or posedge i_rst)
  begin
    if (i_rst)
      idx <= 3'h0;
    else
      idx <= idx + 3'h1;
  end
  // msb first
  assign o_miso = i_tx[3'h7 - idx];
endmodule // spimsd_slave

// ==== tb/test_spimsd_top.sv ====
// self-checking bench for the serial master status and data block
`timescale 1ns/1ps
module test_spimsd_top
  import spimsd_pkg::*;
  ;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, slv;
  logic sck, mosi, miso, ss_n, brg_tick, irq_tx, irq_rx;
  logic [7:0] paddr, slave_tx, slave_rx;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] bcnt;
  int miscompares, n_compared;

  spimsd_top u_dut (.i_clk_sys(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .o_sck(sck), .o_mosi(mosi), .i_miso(miso),
    .i_ss_n(ss_n), .i_brg_tick(brg_tick), .o_irq_tx(irq_tx), .o_irq_rx(irq_rx));
  spimsd_slave u_slave (.i_sck(sck), .i_mosi(mosi), .o_miso(miso), .i_tx(slave_tx),
    .i_rst(srst), .o_rx(slave_rx));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // baud tick every fourth cycle
  always @(posedge clk)
  begin
    bcnt <= bcnt + 2'h1;
    brg_tick <= (bcnt == 2'h3);
  end

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic fail_wait;
    miscompares++;
    $display("mismatch at %0t: wait ran out", $time);
    summarize();
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      fail_wait();
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  task automatic wait_irq;
    int n;
    for (n = 0; n < 8000 && irq_tx !== 1'b1; n++)
      @(posedge clk);
    if (irq_tx !== 1'b1)
      fail_wait();
  endtask

  task automatic t_reset;
    rd_chk(SPIMSD_OFF_CTRL, 32'h14);
    rd_chk(SPIMSD_OFF_STAT, 32'h00);
    rd_chk(8'h0C, 32'h00);
    chk(slv, 1'b1);
  endtask

  task automatic t_exchange;
    apb(1'b1, SPIMSD_OFF_CTRL, 8'h53);
    apb(1'b1, SPIMSD_OFF_DATA, 8'hA5);
    wait_irq();
    rd_chk(SPIMSD_OFF_STAT, 32'h80);
    chk(slave_rx, 8'hA5);
    rd_chk(SPIMSD_OFF_DATA, 32'h3C);
    rd_chk(SPIMSD_OFF_STAT, 32'h00);
  endtask

  task automatic t_collide;
    slave_tx <= 8'hC3;
    apb(1'b1, SPIMSD_OFF_DATA, 8'h5A);
    apb(1'b1, SPIMSD_OFF_DATA, 8'hFF);
    rd_chk(SPIMSD_OFF_STAT, 32'h40);
    wait_irq();
    chk(slave_rx, 8'h5A);
    rd_chk(SPIMSD_OFF_STAT, 32'hC0);
    rd_chk(SPIMSD_OFF_DATA, 32'hC3);
    rd_chk(SPIMSD_OFF_STAT, 32'h00);
  endtask

  task automatic t_fault;
    ss_n <= 1'b0;
    repeat (5) @(posedge clk);
    rd_chk(SPIMSD_OFF_STAT, 32'h10);
    chk(irq_rx, 1'b1);
    ss_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(SPIMSD_OFF_DATA, 32'hC3);
    rd_chk(SPIMSD_OFF_STAT, 32'h00);
    apb(1'b1, SPIMSD_OFF_CTRL, 8'h73);
    ss_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk(irq_rx, 1'b0);
    ss_n <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, SPIMSD_OFF_STAT, 8'h00);
    rd_chk(SPIMSD_OFF_DATA, 32'hC3);
  endtask

  // half period of the serial clock for every rate code, measured on the high phase in mode 0
  task automatic t_rates;
    int code, n;
    for (code = 0; code < 8; code++)
    begin
      apb(1'b1, SPIMSD_OFF_CTRL, {code[2], 5'b10100, code[1:0]});
      apb(1'b1, SPIMSD_OFF_DATA, 8'h00);
      for (n = 0; n < 300 && sck !== 1'b1; n++)
        @(posedge clk);
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (sck === 1'b1 && n < 300);
      chk(n, (code == 7) ? 4 : (1 << code));
      wait_irq();
    end
  endtask

  task automatic t_abort;
    apb(1'b1, SPIMSD_OFF_CTRL, 8'h5B);
    repeat (3) @(posedge clk);
    chk(sck, 1'b1);
    apb(1'b1, SPIMSD_OFF_DATA, 8'h81);
    // stop while the clock sits away from idle, so only the abort can bring it back
    repeat (12) @(posedge clk);
    apb(1'b1, SPIMSD_OFF_CTRL, 8'h1B);
    @(posedge clk);
    chk(sck, 1'b1);
    repeat (300) @(posedge clk);
    chk(irq_tx, 1'b0);
    rd_chk(SPIMSD_OFF_STAT, 32'h00);
  endtask

  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ss_n = 1'b1;
    bcnt = 2'h0;
    brg_tick = 1'b0;
    slave_tx = 8'h3C;
    miscompares = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_exchange();
    t_collide();
    t_fault();
    t_rates();
    t_abort();
    summarize();
  end
endmodule // test_spimsd_top
